// ===== include/ffm_cfg.svh
// Constants of the two-port FIFO flag, mail and parity block.
// Assumes one system clock; port clocks arrive as synchronous levels.
`ifndef FFM_CFG_SVH
`define FFM_CFG_SVH

// ==========================================================
// Geometry
`define FFM_WORD_W    36
`define FFM_PTR_W     7
`define FFM_DEPTH     7'h40
`define FFM_LANES     4
`define FFM_LANE_W    9

// ==========================================================
// Offset presets by select pins
`define FFM_OFS_HH    5'h10
`define FFM_OFS_HL    5'h0c
`define FFM_OFS_LH    5'h08
`define FFM_OFS_LL    5'h04

// ==========================================================
// APB registers
`define FFM_ADDR_W    12
`define FFM_CTRL_ADR  12'h000
`define FFM_STAT_ADR  12'h004
`define FFM_CTRL_ODD  0
`define FFM_CTRL_RST  1'h1
`define FFM_ST_CNT_LO 8
`define FFM_ST_OFS_LO 16

`endif

// ===== include/ffm_pkg.sv
// Types of the two-port FIFO flag, mail and parity block.
// Assumes ffm_cfg.svh is on the include path.
`include "ffm_cfg.svh"

package ffm_pkg;

  // ==========================================================
  // Two-stage flag synchroniser state
  typedef struct packed {
    logic s1;
    logic s2;
  } ffm_sync_s;

  // ==========================================================
  // Core state
  typedef struct packed {
    logic                   a_clk_q;
    logic                   b_clk_q;
    logic                   init_done;
    logic [4:0]             offset;
    logic [`FFM_PTR_W-1:0]  wptr;
    logic [`FFM_PTR_W-1:0]  rptr;
    logic [`FFM_WORD_W-1:0] mail1;
    logic [`FFM_WORD_W-1:0] mail2;
    logic                   mail1_full_n;
    logic                   mail2_full_n;
    logic [`FFM_WORD_W-1:0] fifo_out;
    logic [`FFM_WORD_W-1:0] dout_a;
    logic                   oe_a;
    logic [`FFM_WORD_W-1:0] dout_b;
    logic                   oe_b;
    logic                   pef_a_n;
    logic                   pef_b_n;
    logic                   odd_sel;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
  } ffm_state_s;

endpackage

// ===== core/ffm_parity.sv
// Lane parity checker and generator, shared by check and generation.
// Assumes lanes are packed from bit 0 upward, parity bit on top of each.
`timescale 1ns/1ps
`include "ffm_cfg.svh"

module ffm_parity #(
  parameter int LANES  = `FFM_LANES,
  parameter int LANE_W = `FFM_LANE_W
) (
  // Data and select
  input  wire logic [LANES*LANE_W-1:0] word,
  input  wire logic                    odd_sel,
  // Results
  output logic      [LANES*LANE_W-1:0] gen_word,
  output logic                         err
);
  import ffm_pkg::*;

  logic [LANES-1:0] lane_err;

  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign lane_err[i] = (^word[i*LANE_W +: LANE_W]) ^ odd_sel;
    assign gen_word[i*LANE_W +: LANE_W] =
      {(^word[i*LANE_W +: LANE_W-1]) ^ odd_sel, word[i*LANE_W +: LANE_W-1]};
  end

  assign err = |lane_err;

endmodule // ffm_parity

// ===== core/ffm_sync.sv
// Two-stage flag synchroniser, advanced by a port clock tick.
// Assumes drop is raised in the cycle a local event lowers the level.
`timescale 1ns/1ps

module ffm_sync #(
  parameter bit RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic resetn,
  // Control
  input  wire logic tick,
  input  wire logic drop,
  input  wire logic d,
  // Result
  output logic      q
);
  import ffm_pkg::*;

  ffm_sync_s st;
  ffm_sync_s nx;

  always_comb begin
    nx = st;
    if (drop) begin
      nx.s1 = 1'b0;
      nx.s2 = 1'b0;
    end else if (tick) begin
      nx.s1 = d;
      nx.s2 = st.s1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '{RST_VAL, RST_VAL};
    end else begin
      st <= nx;
    end
  end

  assign q = st.s2;

  property p_sync_rise;
    @(posedge sys_clk) disable iff (!resetn)
    $rose(st.s2) |-> $past(tick) && !$past(drop);
  endproperty
  a_sync_rise: assert property (p_sync_rise) else $error("flag rose without tick");

endmodule // ffm_sync

// ===== core/ffm_core.sv
// 64 x 36 FIFO with almost flags, two mail registers and lane parity.
// Assumes port clocks and all pins are synchronous levels on sys_clk.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "ffm_cfg.svh"

module ffm_core (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    resetn,
  // Port clocks and offset select
  input  wire logic                    port_a_clock,
  input  wire logic                    port_b_clock,
  input  wire logic                    offset_sel0,
  input  wire logic                    offset_sel1,
  // Port A control
  input  wire logic                    chip_sel_port_a_n,
  input  wire logic                    write_not_read_port_a,
  input  wire logic                    port_a_gate,
  input  wire logic                    mail_select_port_a,
  input  wire logic                    gen_parity_port_a,
  // Port A data
  input  wire logic [`FFM_WORD_W-1:0]  port_a_din,
  output logic      [`FFM_WORD_W-1:0]  port_a_dout,
  output logic                         port_a_oe,
  // Port B control
  input  wire logic                    chip_sel_port_b_n,
  input  wire logic                    write_not_read_port_b,
  input  wire logic                    port_b_gate,
  input  wire logic                    mail_select_port_b,
  input  wire logic                    gen_parity_port_b,
  // Port B data
  input  wire logic [`FFM_WORD_W-1:0]  port_b_din,
  output logic      [`FFM_WORD_W-1:0]  port_b_dout,
  output logic                         port_b_oe,
  // Flags
  output logic                         empty_flag_n,
  output logic                         almost_empty_n,
  output logic                         almost_full_n,
  output logic                         full_flag_n,
  output logic                         mail1_full_n,
  output logic                         mail2_full_n,
  output logic                         parity_err_port_a_n,
  output logic                         parity_err_port_b_n,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`FFM_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr
);
  import ffm_pkg::*;

  ffm_state_s             st;
  ffm_state_s             nx;
  logic [`FFM_WORD_W-1:0] mem [0:63];

  logic                   a_tick;
  logic                   b_tick;
  logic                   sel_wr_a;
  logic                   sel_rd_a;
  logic                   sel_wr_b;
  logic                   sel_rd_b;
  logic                   fifo_wr;
  logic                   fifo_rd;
  logic                   mail1_wr;
  logic                   mail2_wr;
  logic                   mail1_rd;
  logic                   mail2_rd;
  logic                   gen_mail_a;
  logic                   gen_mail_b;
  logic [`FFM_PTR_W-1:0]  cnt;
  logic [`FFM_PTR_W-1:0]  ofs7;
  logic                   ef_raw;
  logic                   ae_raw;
  logic                   af_raw;
  logic                   ff_raw;
  logic [`FFM_WORD_W-1:0] tree_a_in;
  logic [`FFM_WORD_W-1:0] tree_b_in;
  logic [`FFM_WORD_W-1:0] gen_a;
  logic [`FFM_WORD_W-1:0] gen_b;
  logic [`FFM_WORD_W-1:0] mem_word;
  logic [`FFM_WORD_W-1:0] gen_fifo;
  logic                   err_a;
  logic                   err_b;
  logic                   apb_done;
  logic [31:0]            status;

  // ==========================================================
  // Port decode
  assign a_tick   = port_a_clock & ~st.a_clk_q;
  assign b_tick   = port_b_clock & ~st.b_clk_q;
  assign sel_wr_a = ~chip_sel_port_a_n & write_not_read_port_a & port_a_gate;
  assign sel_rd_a = ~chip_sel_port_a_n & ~write_not_read_port_a & port_a_gate;
  assign sel_wr_b = ~chip_sel_port_b_n & write_not_read_port_b & port_b_gate;
  assign sel_rd_b = ~chip_sel_port_b_n & ~write_not_read_port_b & port_b_gate;

  assign fifo_wr  = st.init_done & a_tick & sel_wr_a & ~mail_select_port_a & full_flag_n;
  assign fifo_rd  = st.init_done & b_tick & sel_rd_b & ~mail_select_port_b & empty_flag_n;
  assign mail1_wr = a_tick & sel_wr_a & mail_select_port_a & st.mail1_full_n;
  assign mail2_wr = b_tick & sel_wr_b & mail_select_port_b & st.mail2_full_n;
  assign mail1_rd = b_tick & sel_rd_b & mail_select_port_b;
  assign mail2_rd = a_tick & sel_rd_a & mail_select_port_a;
  assign gen_mail_a = sel_rd_a & mail_select_port_a & gen_parity_port_a;
  assign gen_mail_b = sel_rd_b & mail_select_port_b & gen_parity_port_b;

  // ==========================================================
  // Fill level and flag comparisons
  assign cnt    = st.wptr - st.rptr;
  assign ofs7   = {2'h0, st.offset};
  assign ef_raw = cnt != 7'h00;
  assign ae_raw = cnt > ofs7;
  assign af_raw = cnt < 7'(`FFM_DEPTH - ofs7);
  assign ff_raw = cnt != `FFM_DEPTH;

  ffm_sync #(.RST_VAL(1'b0)) u_sync_ef (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .tick    (b_tick),
    .drop    (fifo_rd & ~fifo_wr & (cnt == 7'h01)),
    .d       (ef_raw),
    .q       (empty_flag_n)
  );
  ffm_sync #(.RST_VAL(1'b0)) u_sync_ae (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .tick    (b_tick),
    .drop    (fifo_rd & ~fifo_wr & (cnt == 7'(ofs7 + 7'h01))),
    .d       (ae_raw),
    .q       (almost_empty_n)
  );
  ffm_sync #(.RST_VAL(1'b1)) u_sync_af (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .tick    (a_tick),
    .drop    (fifo_wr & ~fifo_rd & (cnt == 7'(`FFM_DEPTH - ofs7 - 7'h01))),
    .d       (af_raw),
    .q       (almost_full_n)
  );
  ffm_sync #(.RST_VAL(1'b1)) u_sync_ff (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .tick    (a_tick),
    .drop    (fifo_wr & ~fifo_rd & (cnt == 7'(`FFM_DEPTH - 7'h01))),
    .d       (ff_raw),
    .q       (full_flag_n)
  );

  // ==========================================================
  // Parity trees, shared with mail read generation
  // trees read mail, never write it
  assign tree_a_in = gen_mail_a ? st.mail2 : port_a_din;
  assign tree_b_in = gen_mail_b ? st.mail1 : port_b_din;
  assign mem_word  = mem[st.rptr[5:0]];

  ffm_parity u_par_a (
    .word     (tree_a_in),
    .odd_sel  (st.odd_sel),
    .gen_word (gen_a),
    .err      (err_a)
  );
  ffm_parity u_par_b (
    .word     (tree_b_in),
    .odd_sel  (st.odd_sel),
    .gen_word (gen_b),
    .err      (err_b)
  );
  ffm_parity u_par_fifo (
    .word     (mem_word),
    .odd_sel  (st.odd_sel),
    .gen_word (gen_fifo),
    .err      ()
  );

  // ==========================================================
  // APB decode
  assign apb_done = psel & penable & st.pready;
  assign status   = {11'h000, st.offset, 1'h0, cnt, st.pef_b_n, st.pef_a_n,
                     st.mail2_full_n, st.mail1_full_n, full_flag_n, almost_full_n,
                     almost_empty_n, empty_flag_n};

  // ==========================================================
  // Next state
  always_comb begin
    nx = st;
    nx.a_clk_q = port_a_clock;
    nx.b_clk_q = port_b_clock;
    if (!st.init_done) begin
      nx.init_done = 1'h1;
      case ({offset_sel1, offset_sel0})
        2'h3:    nx.offset = `FFM_OFS_HH;
        2'h2:    nx.offset = `FFM_OFS_HL;
        2'h1:    nx.offset = `FFM_OFS_LH;
        default: nx.offset = `FFM_OFS_LL;
      endcase
    end
    if (fifo_wr) begin
      nx.wptr = st.wptr + 7'h01;
    end
    if (fifo_rd) begin
      nx.rptr = st.rptr + 7'h01;
      nx.fifo_out = gen_parity_port_b ? gen_fifo : mem_word;
    end
    if (mail1_rd) begin
      nx.mail1_full_n = 1'h1;
    end
    if (mail2_rd) begin
      nx.mail2_full_n = 1'h1;
    end
    if (mail1_wr) begin
      nx.mail1        = port_a_din;
      nx.mail1_full_n = 1'h0;
    end
    if (mail2_wr) begin
      nx.mail2        = port_b_din;
      nx.mail2_full_n = 1'h0;
    end
    nx.oe_a   = ~chip_sel_port_a_n & ~write_not_read_port_a;
    nx.dout_a = gen_mail_a ? gen_a : st.mail2;
    nx.oe_b   = ~chip_sel_port_b_n & ~write_not_read_port_b;
    if (mail_select_port_b) begin
      nx.dout_b = gen_mail_b ? gen_b : st.mail1;
    end else begin
      nx.dout_b = st.fifo_out;
    end
    nx.pef_a_n = gen_mail_a | ~err_a;
    nx.pef_b_n = gen_mail_b | ~err_b;
    // Register access, answered one cycle into access phase
    nx.pready = psel & penable & ~st.pready;
    if (psel & penable & ~st.pready) begin
      nx.pslverr = (paddr != `FFM_CTRL_ADR) && (paddr != `FFM_STAT_ADR);
      if (paddr == `FFM_CTRL_ADR) begin
        nx.prdata = {31'h00000000, st.odd_sel};
      end else if (paddr == `FFM_STAT_ADR) begin
        nx.prdata = status;
      end else begin
        nx.prdata = 32'h00000000;
      end
    end
    if (apb_done & pwrite & (paddr == `FFM_CTRL_ADR)) begin
      nx.odd_sel = pwdata[`FFM_CTRL_ODD];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st              <= '0;
      st.mail1_full_n <= 1'h1;
      st.mail2_full_n <= 1'h1;
      st.pef_a_n      <= 1'h1;
      st.pef_b_n      <= 1'h1;
      st.odd_sel      <= `FFM_CTRL_RST;
    end else begin
      st <= nx;
    end
  end

  // FIFO array, no reset needed
  always_ff @(posedge sys_clk) begin
    if (fifo_wr) begin
      mem[st.wptr[5:0]] <= port_a_din;
    end
  end

  // ==========================================================
  // Outputs
  assign port_a_dout         = st.dout_a;
  assign port_a_oe           = st.oe_a;
  assign port_b_dout         = st.dout_b;
  assign port_b_oe           = st.oe_b;
  assign mail1_full_n        = st.mail1_full_n;
  assign mail2_full_n        = st.mail2_full_n;
  assign parity_err_port_a_n = st.pef_a_n;
  assign parity_err_port_b_n = st.pef_b_n;
  assign prdata              = st.prdata;
  assign pready              = st.pready;
  assign pslverr             = st.pslverr;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_ae_low;
    !ae_raw |-> !almost_empty_n;
  endproperty
  a_ae_low: assert property (p_ae_low) else $error("almost empty high at low fill");

  property p_ae_edge;
    $rose(almost_empty_n) |-> $past(b_tick) && $past(ae_raw, 2);
  endproperty
  a_ae_edge: assert property (p_ae_edge) else $error("almost empty rose off edge");

  property p_af_low;
    !af_raw |-> !almost_full_n;
  endproperty
  a_af_low: assert property (p_af_low) else $error("almost full high at high fill");

  property p_af_edge;
    $rose(almost_full_n) |-> $past(a_tick) && $past(af_raw, 2);
  endproperty
  a_af_edge: assert property (p_af_edge) else $error("almost full rose off edge");

  property p_offset;
    $rose(st.init_done) |->
      st.offset == 5'(({3'h0, $past(offset_sel1), $past(offset_sel0)} + 5'h01) << 2);
  endproperty
  a_offset: assert property (p_offset) else $error("offset preset wrong");

  property p_mail1_wr;
    mail1_wr |=> st.mail1 == $past(port_a_din) && !mail1_full_n;
  endproperty
  a_mail1_wr: assert property (p_mail1_wr) else $error("mail one write lost");

  property p_mail_hold;
    (!st.mail1_full_n && !mail1_wr) |=> $stable(st.mail1);
  endproperty
  a_mail_hold: assert property (p_mail_hold) else $error("mail one changed while full");

  property p_mail1_rd;
    (mail1_rd && !mail1_wr) |=> mail1_full_n ##1 (mail1_full_n || $past(mail1_wr));
  endproperty
  a_mail1_rd: assert property (p_mail1_rd) else $error("mail one flag not set");

  property p_mail2_rd;
    (mail2_rd && !mail2_wr) |=> mail2_full_n;
  endproperty
  a_mail2_rd: assert property (p_mail2_rd) else $error("mail two flag not set");

  property p_pef_hold;
    gen_mail_a |=> parity_err_port_a_n;
  endproperty
  a_pef_hold: assert property (p_pef_hold) else $error("port A error during generation");

  property p_pef_err;
    (!gen_mail_b && err_b) |=> !parity_err_port_b_n;
  endproperty
  a_pef_err: assert property (p_pef_err) else $error("port B error not flagged");

  property p_fifo_par;
    (fifo_rd && gen_parity_port_b) |=>
      ((^st.fifo_out[8:0]) == st.odd_sel) && ((^st.fifo_out[35:27]) == st.odd_sel);
  endproperty
  a_fifo_par: assert property (p_fifo_par) else $error("fifo read parity wrong");

  c_mail_trip: cover property (mail1_wr ##[1:50] mail1_rd);
  c_ae_rise:   cover property ($rose(almost_empty_n));
  c_af_fall:   cover property ($fell(almost_full_n));
  c_pef:       cover property ($fell(parity_err_port_a_n));

endmodule // ffm_core

// ===== verif/ffm_host.sv
// Far-side model: free-running port clocks and both shared data buses.
// Assumes the bench drives host levels just after sys_clk rising edges.
`timescale 1ns/1ps

module ffm_host (
  // Clock
  input  wire logic        sys_clk,
  // Host drive
  input  wire logic [35:0] host_a,
  input  wire logic        host_a_oe,
  input  wire logic [35:0] host_b,
  input  wire logic        host_b_oe,
  // Device drive
  input  wire logic [35:0] dev_a,
  input  wire logic        dev_a_oe,
  input  wire logic [35:0] dev_b,
  input  wire logic        dev_b_oe,
  // Port clocks and wire levels
  output logic             port_a_clock,
  output logic             port_b_clock,
  output logic [35:0]      bus_a,
  output logic [35:0]      bus_b
);
  logic [3:0]  cnt_ff = 4'h0;
  logic [35:0] last_a_ff = 36'h0;
  logic [35:0] last_b_ff = 36'h0;

  // ==========================================================
  // Clocks: port A period 4, port B period 6
  always_ff @(posedge sys_clk) begin
    cnt_ff <= (cnt_ff == 4'hb) ? 4'h0 : cnt_ff + 4'h1;
    last_a_ff <= bus_a;
    last_b_ff <= bus_b;
  end
  assign port_a_clock = cnt_ff[1];
  assign port_b_clock = (cnt_ff >= 4'h3 && cnt_ff < 4'h6) || cnt_ff >= 4'h9;

  // ==========================================================
  // Wire: contention unknown, released bus keeps changing
  function automatic logic [35:0] res(input logic h, d, input logic [35:0] hv, dv, lv);
    if (h && d) begin
      return {36{1'bx}};
    end
    return h ? hv : (d ? dv : ~lv);
  endfunction
  assign bus_a = res(host_a_oe, dev_a_oe, host_a, dev_a, last_a_ff);
  assign bus_b = res(host_b_oe, dev_b_oe, host_b, dev_b, last_b_ff);
endmodule // ffm_host

// ===== verif/testbench.sv
// Bench: port and register tasks driving ffm_core, host model on the buses.
// Assumes ffm_cfg.svh on the include path and odd parity out of reset.
`timescale 1ns/1ps

module testbench;
  import ffm_pkg::*;
  logic        sys_clk, resetn, offset_sel0, offset_sel1, psel, penable, pwrite;
  logic        chip_sel_port_a_n, write_not_read_port_a, port_a_gate;
  logic        mail_select_port_a, gen_parity_port_a, host_a_oe, port_a_oe;
  logic        chip_sel_port_b_n, write_not_read_port_b, port_b_gate;
  logic        mail_select_port_b, gen_parity_port_b, host_b_oe, port_b_oe;
  logic        port_a_clock, port_b_clock, pready, pslverr, er, pe;
  logic        empty_flag_n, almost_empty_n, almost_full_n, full_flag_n;
  logic        mail1_full_n, mail2_full_n, parity_err_port_a_n, parity_err_port_b_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [35:0] port_a_din, port_b_din, port_a_dout, port_b_dout, host_a, host_b, sd;
  int          n_mismatch, n_tests, cycles;

  ffm_core DUT (.*);
  ffm_host host (.sys_clk(sys_clk), .host_a(host_a), .host_a_oe(host_a_oe),
    .host_b(host_b), .host_b_oe(host_b_oe), .dev_a(port_a_dout), .dev_a_oe(port_a_oe),
    .dev_b(port_b_dout), .dev_b_oe(port_b_oe), .port_a_clock(port_a_clock),
    .port_b_clock(port_b_clock), .bus_a(port_a_din), .bus_b(port_b_din));

  // ==========================================================
  // Helpers
  function automatic logic [35:0] wd(input int i);
    return 36'h5a5a5a5a5 ^ {4{9'(i)}};
  endfunction
  function automatic logic [35:0] gen(input logic [35:0] w);
    gen = w;
    for (int l = 0; l < 4; l++) begin
      gen[l*9+8] = ~^w[l*9 +: 8];
    end
  endfunction
  task automatic give_verdict();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [35:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chkb(input string nm, input logic exp, got);
    chk(nm, {35'h0, exp}, {35'h0, got});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic rise(input bit b);
    logic p;
    do begin
      p = b ? port_b_clock : port_a_clock;
      @(posedge sys_clk);
    end while (!(b ? port_b_clock : port_a_clock) || p);
  endtask
  task automatic op(input bit b, input logic w, m, g, input logic [35:0] d);
    rise(b);
    if (b) begin
      chip_sel_port_b_n <= 1'h0;
      write_not_read_port_b <= w;
      port_b_gate <= 1'h1;
      mail_select_port_b <= m;
      gen_parity_port_b <= g;
      host_b <= d;
      host_b_oe <= w;
    end else begin
      chip_sel_port_a_n <= 1'h0;
      write_not_read_port_a <= w;
      port_a_gate <= 1'h1;
      mail_select_port_a <= m;
      gen_parity_port_a <= g;
      host_a <= d;
      host_a_oe <= w;
    end
    rise(b);
    pe = b ? parity_err_port_b_n : parity_err_port_a_n;
    sd = b ? port_b_dout : port_a_dout;
    port_a_gate <= 1'h0;
    port_b_gate <= 1'h0;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do @(posedge sys_clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic rst(input logic [1:0] s);
    {offset_sel1, offset_sel0} <= s;
    resetn <= 1'h0;
    cyc(2);
    resetn <= 1'h1;
    cyc(2);
  endtask

  // ==========================================================
  // Clock, timeout, sequence
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    {resetn, offset_sel0, offset_sel1, psel, penable, pwrite, host_a_oe, host_b_oe} = 8'h0;
    {chip_sel_port_a_n, write_not_read_port_a, port_a_gate} = 3'h4;
    {mail_select_port_a, gen_parity_port_a} = 2'h0;
    {chip_sel_port_b_n, write_not_read_port_b, port_b_gate} = 3'h4;
    {mail_select_port_b, gen_parity_port_b} = 2'h0;
    {paddr, pwdata, host_a, host_b} = 116'h0;
    for (int i = 3; i >= 0; i--) begin
      rst(2'(i));
      apb(1'h0, 12'h004, 32'h0);
      chk("offset", 36'(5'h04 + 5'(i) * 5'h04), {31'h0, rd[20:16]});
    end
    chk("flags", 36'h0f, {30'h0, empty_flag_n, almost_empty_n, almost_full_n, full_flag_n,
      mail1_full_n, mail2_full_n});
    apb(1'h0, 12'h000, 32'h0);
    chkb("ctrl", 1'h1, rd[0]);
    apb(1'h0, 12'h008, 32'h0);
    chkb("unmapped", 1'h1, er);
    for (int i = 0; i < 65; i++) begin
      op(1'h0, 1'h1, 1'h0, 1'(i == 0), wd(i));
      if (i == 4) begin
        rise(1'h1);
        chkb("ae_low", 1'h0, almost_empty_n);
        cyc(1);
        chkb("ae_sync1", 1'h0, almost_empty_n);
        rise(1'h1);
        cyc(1);
        chkb("ae_high", 1'h1, almost_empty_n);
      end
      cyc(1);
      if (i == 3) chkb("ae_low", 1'h0, almost_empty_n);
      if (i == 58) chkb("af_high", 1'h1, almost_full_n);
      if (i == 59) chkb("af_low", 1'h0, almost_full_n);
      if (i == 63) chkb("full", 1'h0, full_flag_n);
    end
    apb(1'h0, 12'h004, 32'h0);
    chk("count", 36'h40, {29'h0, rd[14:8]});
    for (int i = 0; i < 5; i++) begin
      op(1'h1, 1'h0, 1'h0, 1'(i == 1), 36'h0);
      cyc(2);
      chk("fifo_q", (i == 1) ? gen(wd(1)) : wd(i), port_b_dout);
    end
    chkb("af_hold", 1'h0, almost_full_n);
    rise(1'h0);
    rise(1'h0);
    rise(1'h0);
    cyc(2);
    chkb("af_rise", 1'h1, almost_full_n);
    op(1'h0, 1'h1, 1'h1, 1'h0, 36'h123456789);
    cyc(2);
    chkb("mail1_flag", 1'h0, mail1_full_n);
    op(1'h0, 1'h1, 1'h1, 1'h0, 36'h0abcdef01);
    op(1'h1, 1'h0, 1'h1, 1'h0, 36'h0);
    chk("mail1", 36'h123456789, sd);
    cyc(2);
    chkb("mail1_read", 1'h1, mail1_full_n);
    op(1'h1, 1'h0, 1'h1, 1'h1, 36'h0);
    chk("mail1_gen", gen(36'h123456789), sd);
    chkb("pe_b_held", 1'h1, pe);
    op(1'h1, 1'h0, 1'h1, 1'h0, 36'h0);
    chk("mail1_again", 36'h123456789, sd);
    chkb("oe_b", 1'h1, port_b_oe);
    op(1'h1, 1'h1, 1'h1, 1'h0, 36'h0fedcba98);
    cyc(2);
    chkb("mail2_flag", 1'h0, mail2_full_n);
    op(1'h0, 1'h0, 1'h1, 1'h0, 36'h0);
    chk("mail2", 36'h0fedcba98, sd);
    cyc(2);
    chkb("mail2_read", 1'h1, mail2_full_n);
    chkb("oe_a", 1'h1, port_a_oe);
    chip_sel_port_a_n <= 1'h1;
    chip_sel_port_b_n <= 1'h1;
    host_a_oe <= 1'h1;
    host_b_oe <= 1'h1;
    for (int l = 0; l < 5; l++) begin
      host_a <= 36'hfffffffff ^ ((l < 4) ? (36'h1 << (l * 9)) : 36'h0);
      host_b <= 36'hfffffffff ^ ((l < 4) ? (36'h100 << (l * 9)) : 36'h0);
      cyc(3);
      chkb("pe_a", 1'(l == 4), parity_err_port_a_n);
      chkb("pe_b", 1'(l == 4), parity_err_port_b_n);
    end
    apb(1'h1, 12'h000, 32'h0);
    cyc(2);
    chkb("pe_a_even", 1'h0, parity_err_port_a_n);
    chkb("pe_b_even", 1'h0, parity_err_port_b_n);
    give_verdict();
  end
endmodule // testbench
